// file: dca_pkg.sv
// shared constants and types of the driver chain datagram assembler
package dca_pkg;

    // ****************************************************************
    // configuration area geometry
    // ****************************************************************
    localparam int CFG_WORDS = 32;    // ram words used for configuration
    localparam int CFG_ENTRIES = 64;  // two entries per word
    localparam int ADDR_W = 5;
    localparam int ENTRY_W = 6;
    localparam int ENT_IDX_W = 6;
    localparam int CODE_W = 5;
    localparam int FLAG_POS = 5;      // next_driver_flag above the code
    localparam int WORD_W = 2 * ENTRY_W;
    localparam int NUM_DRV = 3;
    localparam int DRV_W = 2;
    localparam int DAC_W = 6;

    // ****************************************************************
    // primary signal codes
    // ****************************************************************
    localparam logic [CODE_W-1:0] CODE_A_DAC0 = 5'h00;
    localparam logic [CODE_W-1:0] CODE_A_DAC5 = 5'h05;
    localparam logic [CODE_W-1:0] CODE_A_POL = 5'h06;
    localparam logic [CODE_W-1:0] CODE_A_FD = 5'h07;
    localparam logic [CODE_W-1:0] CODE_B_DAC0 = 5'h08;
    localparam logic [CODE_W-1:0] CODE_B_DAC5 = 5'h0d;
    localparam logic [CODE_W-1:0] CODE_B_POL = 5'h0e;
    localparam logic [CODE_W-1:0] CODE_B_FD = 5'h0f;
    localparam logic [CODE_W-1:0] CODE_ZERO = 5'h10;
    localparam logic [CODE_W-1:0] CODE_ONE = 5'h11;
    localparam logic [CODE_W-1:0] CODE_DIR = 5'h12;
    localparam logic [CODE_W-1:0] CODE_STEP = 5'h13;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [DRV_W-1:0] DRV_RST = 2'h0;
    localparam logic [ENT_IDX_W-1:0] ENT_RST = 6'h00;
    localparam logic SDO_RST = 1'b0;
    localparam logic SEL_N_RST = 1'b1;
    localparam logic LK_IDLE = 1'b1;  // link clock stands high between frames

    // primary signals of one motor
    typedef struct packed {
        logic [DAC_W-1:0] dac_a;
        logic             coil_a_polarity;
        logic             coil_a_fast_decay;
        logic [DAC_W-1:0] dac_b;
        logic             coil_b_polarity;
        logic             coil_b_fast_decay;
        logic             direction;
        logic             step;
    } dca_motor_t;

    // 32 bit host datagram for the configuration area
    typedef struct packed {
        logic              top;      // must be set
        logic              ram_sel;  // must be clear for this area
        logic [ADDR_W-1:0] addr;
        logic              rw;       // clear: write, set: read
        logic [9:0]        unused;
        logic [ENTRY_W-1:0] odd;
        logic [1:0]        gap;
        logic [ENTRY_W-1:0] even;
    } dca_host_word_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_WAIT_FALL,
        ST_WAIT_RISE
    } dca_state_t;

endpackage

// file: dca_cfg_ram.sv
// configuration ram: 32 words of two entries, host port and fetch port
`timescale 1ns/1ps
module dca_cfg_ram
    import dca_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              ce_i,
    input  wire logic              wr_en_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [WORD_W-1:0] wr_data_i,
    input  wire logic [ADDR_W-1:0] host_addr_i,
    output logic      [WORD_W-1:0] host_data_o,
    input  wire logic [ADDR_W-1:0] fetch_addr_i,
    output logic      [WORD_W-1:0] fetch_data_o
);

    // ****************************************************************
    // storage
    // ****************************************************************
    // no reset: contents are arbitrary after power-up
    logic [WORD_W-1:0] mem [CFG_WORDS];

    // both read ports are registered; the host port never waits
    always_ff @(posedge clk_i)
    begin
        if (ce_i)
        begin
            if (wr_en_i)
            begin
                mem[wr_addr_i] <= wr_data_i;
            end
            host_data_o  <= mem[host_addr_i];
            fetch_data_o <= mem[fetch_addr_i];
        end
    end

endmodule

// file: dca_assembler.sv
// driver chain datagram assembler: snapshot, config fetch, serial out
`timescale 1ns/1ps

module dca_assembler
    import dca_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    input  wire dca_motor_t [NUM_DRV-1:0] motor_sig_i,
    input  wire logic                   tx_req_i,
    input  wire logic [DRV_W-1:0]       last_driver_index_i,
    input  wire logic                   host_valid_i,
    input  wire dca_host_word_t         host_word_i,
    output logic                        host_rvalid_o,
    output logic      [WORD_W-1:0]      host_rdata_o,
    input  wire logic                   link_clk_i,
    output logic                        link_sel_n_o,
    output logic                        link_data_o,
    output logic                        busy_o
);

    // ****************************************************************
    // signal selection
    // ****************************************************************
    // one code picks one primary signal of the selected driver
    function automatic logic sel_bit(input dca_motor_t m,
                                     input logic [CODE_W-1:0] code);
        logic b;
        b = 1'b0;
        if (code >= CODE_A_DAC0 && code <= CODE_A_DAC5)
        begin
            b = m.dac_a[code[2:0]];
        end
        else if (code >= CODE_B_DAC0 && code <= CODE_B_DAC5)
        begin
            b = m.dac_b[code[2:0]];
        end
        else
        begin
            case (code)
                CODE_A_POL: b = m.coil_a_polarity;
                CODE_A_FD:  b = m.coil_a_fast_decay;
                CODE_B_POL: b = m.coil_b_polarity;
                CODE_B_FD:  b = m.coil_b_fast_decay;
                CODE_ZERO:  b = 1'b0;
                CODE_ONE:   b = 1'b1;
                CODE_DIR:   b = m.direction;
                CODE_STEP:  b = m.step;
                default:    b = 1'b0;  // unused codes send zero
            endcase
        end
        return b;
    endfunction

    // ****************************************************************
    // link clock synchroniser and edge finder
    // ****************************************************************
    logic lk_meta_r;
    logic lk_sync_r;
    logic lk_prev_r;
    logic lk_meta_nxt;
    logic lk_sync_nxt;
    logic lk_prev_nxt;
    logic lk_fall;
    logic lk_rise;

    // two flops before use; the first is never looked at, edges come from the second and its delayed copy
    always_comb
    begin
        lk_meta_nxt = link_clk_i;
        lk_sync_nxt = lk_meta_r;
        lk_prev_nxt = lk_sync_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lk_meta_r <= LK_IDLE;  // idle level: no false edge after reset
            lk_sync_r <= LK_IDLE;
            lk_prev_r <= LK_IDLE;
        end
        else if (ce_i)
        begin
            lk_meta_r <= lk_meta_nxt;
            lk_sync_r <= lk_sync_nxt;
            lk_prev_r <= lk_prev_nxt;
        end
    end

    assign lk_fall = lk_prev_r & ~lk_sync_r;
    assign lk_rise = ~lk_prev_r & lk_sync_r;

    // ****************************************************************
    // host access to the configuration ram
    // ****************************************************************
    logic              host_hit;
    logic              host_wr;
    logic              host_rd;
    logic              rd_pend_r;
    logic              rd_pend_nxt;
    logic [WORD_W-1:0] fetch_word;
    logic [ADDR_W-1:0] fetch_addr;

    // only words aimed at this area are taken; others are ignored
    assign host_hit = host_valid_i & host_word_i.top & ~host_word_i.ram_sel;
    assign host_wr  = host_hit & ~host_word_i.rw;
    assign host_rd  = host_hit & host_word_i.rw;

    always_comb
    begin
        rd_pend_nxt = host_rd;           // no busy check at all
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_pend_r <= 1'b0;
        end
        else if (ce_i)
        begin
            rd_pend_r <= rd_pend_nxt;
        end
    end

    assign host_rvalid_o = rd_pend_r;

    // odd entry in the upper half of a word, even in the lower
    dca_cfg_ram u_ram (
        .clk_i        (clk_i),
        .ce_i         (ce_i),
        .wr_en_i      (host_wr),
        .wr_addr_i    (host_word_i.addr),
        .wr_data_i    ({host_word_i.odd, host_word_i.even}),
        .host_addr_i  (host_word_i.addr),
        .host_data_o  (host_rdata_o),
        .fetch_addr_i (fetch_addr),
        .fetch_data_o (fetch_word)
    );

    // ****************************************************************
    // datagram sequencer
    // ****************************************************************
    dca_state_t                 state_r;
    dca_state_t                 state_nxt;
    dca_motor_t [NUM_DRV-1:0]   snap_r;
    dca_motor_t [NUM_DRV-1:0]   snap_nxt;
    logic [DRV_W-1:0]           drv_r;
    logic [DRV_W-1:0]           drv_nxt;
    logic [ENT_IDX_W-1:0]       ent_r;
    logic [ENT_IDX_W-1:0]       ent_nxt;
    logic                       flag_r;
    logic                       flag_nxt;
    logic                       sdo_r;
    logic                       sdo_nxt;
    logic                       sel_n_r;
    logic                       sel_n_nxt;
    logic [ENTRY_W-1:0]         entry;
    dca_motor_t                 cur_sig;

    // entry index bit 0 picks the half of the word
    assign fetch_addr = ent_r[ENT_IDX_W-1:1];
    assign entry = ent_r[0] ? fetch_word[WORD_W-1:ENTRY_W]
                            : fetch_word[ENTRY_W-1:0];
    // position selects the driver; no address goes out
    assign cur_sig = (drv_r < DRV_W'(NUM_DRV)) ? snap_r[drv_r] : '0;

    // sequencing: bits move on link falls, advance on link rises
    always_comb
    begin
        state_nxt = state_r;
        snap_nxt  = snap_r;
        drv_nxt   = drv_r;
        ent_nxt   = ent_r;
        flag_nxt  = flag_r;
        sdo_nxt   = sdo_r;
        sel_n_nxt = sel_n_r;
        case (state_r)
            ST_IDLE:
            begin
                if (tx_req_i)
                begin
                    snap_nxt  = motor_sig_i;
                    drv_nxt   = DRV_RST;
                    ent_nxt   = ENT_RST;
                    sel_n_nxt = 1'b0;
                    state_nxt = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                // one cycle for the registered ram read to settle
                state_nxt = ST_WAIT_FALL;
            end
            ST_WAIT_FALL:
            begin
                if (lk_fall)
                begin
                    sdo_nxt   = sel_bit(cur_sig, entry[CODE_W-1:0]);
                    flag_nxt  = entry[FLAG_POS];
                    state_nxt = ST_WAIT_RISE;
                end
            end
            ST_WAIT_RISE:
            begin
                if (lk_rise)
                begin
                    // wraps 63 to 0, so no flag means no end
                    ent_nxt   = ent_r + ENT_IDX_W'(1);
                    state_nxt = ST_FETCH;
                    if (flag_r && drv_r == last_driver_index_i)
                    begin
                        drv_nxt   = DRV_RST;
                        sel_n_nxt = SEL_N_RST;
                        state_nxt = ST_IDLE;
                    end
                    else if (flag_r)
                    begin
                        drv_nxt = drv_r + DRV_W'(1);
                    end
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // reset leaves the sequencer idle with the frame closed
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_IDLE;
            snap_r  <= '0;
            drv_r   <= DRV_RST;
            ent_r   <= ENT_RST;
            flag_r  <= 1'b0;
            sdo_r   <= SDO_RST;
            sel_n_r <= SEL_N_RST;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
            snap_r  <= snap_nxt;
            drv_r   <= drv_nxt;
            ent_r   <= ent_nxt;
            flag_r  <= flag_nxt;
            sdo_r   <= sdo_nxt;
            sel_n_r <= sel_n_nxt;
        end
    end

    assign link_data_o  = sdo_r;
    assign link_sel_n_o = sel_n_r;
    assign busy_o       = (state_r != ST_IDLE);

    // ****************************************************************
    // assertions
    // ****************************************************************
    reset_idle_a: assert property (
        @(posedge clk_i) $past(rst_i) |-> !busy_o && link_sel_n_o)
        else $error("not idle after reset");

    start_zero_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !busy_o && tx_req_i) |=>
            busy_o && drv_r == '0 && ent_r == '0 && !link_sel_n_o)
        else $error("transmission did not start at zero");

    snap_hold_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (busy_o && $past(busy_o)) |-> $stable(snap_r))
        else $error("snapshot changed during transmission");

    end_reinit_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && state_r == ST_WAIT_RISE && lk_rise && flag_r &&
         drv_r == last_driver_index_i) |=>
            !busy_o && drv_r == '0 && link_sel_n_o)
        else $error("transmission did not end at last driver");

    drv_step_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && state_r == ST_WAIT_RISE && lk_rise && flag_r &&
         drv_r != last_driver_index_i) |=>
            drv_r == $past(drv_r) + 2'h1 && state_r == ST_FETCH)
        else $error("driver index did not advance");

    ent_order_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && state_r == ST_WAIT_RISE && lk_rise) |=>
            ent_r == $past(ent_r) + 6'h01)
        else $error("entry index did not step by one");

    no_flag_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && state_r == ST_WAIT_RISE && lk_rise && !flag_r) |=>
            busy_o && drv_r == $past(drv_r))
        else $error("transmission stopped without a flag");

    host_read_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && host_rd) |=> host_rvalid_o)
        else $error("host read not answered");

    bit_select_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && state_r == ST_WAIT_FALL && lk_fall &&
         entry[CODE_W-1:0] == CODE_ONE) |=> link_data_o)
        else $error("constant one code did not send one");

    flag_latch_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && state_r == ST_WAIT_FALL && lk_fall) |=>
            flag_r == $past(entry[FLAG_POS]) && state_r == ST_WAIT_RISE)
        else $error("next driver flag not taken");

endmodule

// file: dca_chain_model.sv
// behavioural daisy chain of driver chips on the serial link
`timescale 1ns/1ps
module dca_chain_model
(
    input  wire logic link_sel_n_i,
    input  wire logic link_data_i,
    output logic      link_clk_o
);
    // ****************************************************************
    // link clock and bit capture
    // ****************************************************************
    logic got_q[$];  // bits in arrival order; position is the only address

    // clock stands high between frames, bit taken on each rising edge
    initial
    begin
        link_clk_o = 1'b1;
        forever
        begin
            wait (link_sel_n_i == 1'b0);
            #32;
            // re-check: a frame may have closed during the high phase
            if (link_sel_n_i == 1'b0)
            begin
                link_clk_o = 1'b0;
                #32;
                link_clk_o = 1'b1;
                got_q.push_back(link_data_i);
            end
        end
    end
endmodule

// file: test_dca_assembler.sv
// self-checking bench of the driver chain datagram assembler
`timescale 1ns/1ps
module test_dca_assembler
    import dca_pkg::*;
();
    // ****************************************************************
    // stimulus, bench state and expectation
    // ****************************************************************
    logic                     clk_i, rst_i, ce_i, tx_req_i, host_valid_i;
    logic                     link_clk, host_rvalid, link_sel_n, link_data;
    logic                     busy;
    dca_motor_t [NUM_DRV-1:0] motor_sig;
    logic [DRV_W-1:0]         last_drv;
    dca_host_word_t           host_word;
    logic [WORD_W-1:0]        host_rdata;
    logic [ENTRY_W-1:0]       ent [CFG_ENTRIES];  // bench copy of the ram
    logic                     exp_q[$];
    int                       failures, checks_done;
    integer                   seed = 32'h1dde;
    localparam int SIG_W = NUM_DRV * $bits(dca_motor_t);
    logic [ENTRY_W-1:0]       ex [30] = '{6'h0e, 6'h0c, 6'h0b, 6'h0a,
        6'h09, 6'h08, 6'h06, 6'h04, 6'h03, 6'h02, 6'h01, 6'h20, 6'h10,
        6'h10, 6'h10, 6'h11, 6'h11, 6'h11, 6'h13, 6'h32, 6'h0f, 6'h07,
        6'h0e, 6'h0a, 6'h09, 6'h08, 6'h06, 6'h02, 6'h01, 6'h20};

    dca_assembler i_dca_assembler (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .motor_sig_i(motor_sig),
        .tx_req_i(tx_req_i), .last_driver_index_i(last_drv),
        .host_valid_i(host_valid_i), .host_word_i(host_word),
        .host_rvalid_o(host_rvalid), .host_rdata_o(host_rdata),
        .link_clk_i(link_clk), .link_sel_n_o(link_sel_n),
        .link_data_o(link_data), .busy_o(busy));

    dca_chain_model i_dca_chain_model (
        .link_sel_n_i(link_sel_n), .link_data_i(link_data),
        .link_clk_o(link_clk));

    // 250 MHz system clock
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // signal picked by a code; unused codes give zero
    function automatic logic sig_bit(dca_motor_t m, logic [CODE_W-1:0] c);
        logic [19:0] v;
        v = {m.step, m.direction, 1'b1, 1'b0, m.coil_b_fast_decay,
             m.coil_b_polarity, m.dac_b, m.coil_a_fast_decay,
             m.coil_a_polarity, m.dac_a};
        return (c < 5'h14) ? v[c] : 1'b0;
    endfunction

    // walk the config as the chain should see it
    function automatic void expect_frame(dca_motor_t [NUM_DRV-1:0] s, int lim);
        int e;
        int d;
        e = 0;
        d = 0;
        exp_q.delete();
        while (exp_q.size() < lim)
        begin
            exp_q.push_back(sig_bit(s[d], ent[e][CODE_W-1:0]));
            if (ent[e][FLAG_POS])
            begin
                if (d == int'(last_drv))
                    break;
                d++;
            end
            e = (e + 1) % CFG_ENTRIES;
        end
    endfunction

    task automatic cmp_bit(string n, logic e, logic g);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_word(string n, logic [WORD_W-1:0] e,
                            logic [WORD_W-1:0] g);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_num(string n, int e, int g);
        checks_done++;
        if (g != e)
        begin
            failures++;
            $display("FAIL %s expected %0d seen %0d", n, e, g);
        end
    endtask

    task automatic conclude;
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one host word; k = {ram_sel, top}, anything but 01 must be ignored
    task automatic host_acc(logic rw, logic [ADDR_W-1:0] a, logic [1:0] k);
        @(posedge clk_i);
        host_valid_i <= 1'b1;
        host_word <= '{top: k[0], ram_sel: k[1], addr: a, rw: rw,
                       unused: 10'h000, gap: 2'h0,
                       odd: (k == 2'b01) ? ent[2*a+1] : ~ent[2*a+1],
                       even: (k == 2'b01) ? ent[2*a] : ~ent[2*a]};
        @(posedge clk_i);
        host_valid_i <= 1'b0;
        if (rw)
        begin
            // the answer stands only in the cycle after the taking edge
            #1;
            cmp_bit("read valid", 1'b1, host_rvalid);
            cmp_word("read word", {ent[2*a+1], ent[2*a]}, host_rdata);
        end
    endtask

    task automatic fill(logic rw);
        for (int a = 0; a < CFG_WORDS; a++)
            host_acc(rw, 5'(a), 2'b01);
    endtask

    task automatic idle_check;
        cmp_bit("busy", 1'b0, busy);
        cmp_bit("select", 1'b1, link_sel_n);
        cmp_bit("link data", 1'b0, link_data);
        cmp_bit("read valid", 1'b0, host_rvalid);
    endtask

    // one request; host traffic and a dropped request ride along
    task automatic run_frame(bit endless);
        dca_motor_t [NUM_DRV-1:0] snap;
        int n;
        logic got[$];
        @(posedge clk_i);
        tx_req_i <= 1'b1;
        #1;
        snap = motor_sig;
        expect_frame(snap, endless ? 70 : 3 * CFG_ENTRIES);
        i_dca_chain_model.got_q.delete();
        @(posedge clk_i);
        tx_req_i <= 1'b0;
        motor_sig <= SIG_W'({$random(seed), $random(seed)});
        @(posedge clk_i);
        #1;
        cmp_bit("busy", 1'b1, busy);
        cmp_bit("select", 1'b0, link_sel_n);
        host_acc(1'b1, 5'h00, 2'b01);
        host_acc(1'b1, 5'h1f, 2'b01);
        @(posedge clk_i);
        tx_req_i <= 1'b1;
        @(posedge clk_i);
        tx_req_i <= 1'b0;
        n = 0;
        while (n < 20000 && (endless ? i_dca_chain_model.got_q.size() < 70
                                     : busy !== 1'b0))
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        got = i_dca_chain_model.got_q;
        cmp_bit("busy", endless, busy);
        cmp_bit("select", !endless, link_sel_n);
        if (!endless)
            cmp_num("bits", exp_q.size(), got.size());
        for (int i = 0; i < exp_q.size(); i++)
            if (i < got.size())
                cmp_bit("link bit", exp_q[i], got[i]);
        if (!endless)
        begin
            // the request made while busy must not start a second frame
            repeat (24) @(posedge clk_i);
            #1;
            cmp_bit("busy", 1'b0, busy);
        end
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial
    begin
        failures = 0;
        checks_done = 0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        tx_req_i = 1'b0;
        host_valid_i = 1'b0;
        host_word = '0;
        motor_sig = '0;
        last_drv = 2'h2;
        repeat (8) @(posedge clk_i);
        #1;
        idle_check();
        @(posedge clk_i);
        rst_i <= 1'b0;
        // worked three-driver layout first, tail filled at random
        foreach (ent[i])
            ent[i] = (i < 30) ? ex[i] : 6'($random(seed));
        fill(1'b0);
        host_acc(1'b0, 5'h03, 2'b00);
        host_acc(1'b0, 5'h04, 2'b11);
        fill(1'b1);
        @(posedge clk_i);
        motor_sig <= SIG_W'({$random(seed), $random(seed)});
        run_frame(1'b0);
        run_frame(1'b0);
        // random layouts; last entry flagged so every frame ends
        repeat (4)
        begin
            foreach (ent[i])
                ent[i] = {($random(seed) & 7) == 0, 5'($random(seed))};
            ent[CFG_ENTRIES-1][FLAG_POS] = 1'b1;
            last_drv <= 2'($unsigned($random(seed)) % 3);
            fill(1'b0);
            run_frame(1'b0);
        end
        // no flag anywhere: the frame never closes
        foreach (ent[i])
            ent[i][FLAG_POS] = 1'b0;
        fill(1'b0);
        run_frame(1'b1);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        idle_check();
        @(posedge clk_i);
        rst_i <= 1'b0;
        fill(1'b1);
        conclude();
    end

    // the whole run needs well under this span
    initial
    begin
        #400000;
        failures++;
        conclude();
    end
endmodule
